// *** rtl/acquisition_trigger_control.sv ***
// Start trigger control and triggered scan capture for the acquisition engine
// Functional notes
// - The digital trigger input starts on the rising or the falling edge, as configured.
// - On the two active-low trigger pins a high-to-low change is the trigger event.
// - Once triggered with all conditions met, post-trigger capture begins with no further event.
// - The start trigger comes from a software command or an external input, by configuration.
// - With a nonzero pretrigger count, scans are kept before the trigger and total minus pre after.
// - With a zero pretrigger count, nothing is kept before and the full count is taken after.
// - A time limit bounds the wait for trigger plus data, and waiting stops when it expires.
// - Trigger type selects one trigger or start-and-stop, the latter used only with both triggers.
// - In analog mode the selected channel is watched and capture waits for its condition.
// - The analog trigger fires when the signal reaches the level while moving in the set direction.
// - Any ordinary input channel, data channels included, may serve as the analog source.
// - Scans go into a memory buffer whose contents are readable once the capture completes.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
module acquisition_trigger_control
#(
  parameter int DATA_W = 16,
  parameter int DEPTH  = 1024,
  parameter int CHAN_W = 4
) (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic [acq_trig_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [acq_trig_pkg::REG_DW-1:0]  reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [acq_trig_pkg::REG_DW-1:0]  reg_rdata,
  input  wire logic                             start_trigger_in_n,
  input  wire logic                             external_trigger_in_n,
  input  wire logic                             digital_trigger_in,
  input  wire logic                             sample_valid,
  input  wire logic [CHAN_W-1:0]                sample_chan,
  input  wire logic [DATA_W-1:0]                sample_data,
  output logic                                  acq_busy,
  output logic                                  acq_done
);
  import acq_trig_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || DATA_W > REG_DW || DATA_W < 2
      || CHAN_W > REG_DW || AW >= CNT_W) begin : g_param_check
    $error("acquisition_trigger_control: unsupported parameters");
  end

  buf_if #(.AW(AW), .DW(DATA_W)) mem_bus ();

  scan_buffer #(.AW(AW), .DW(DATA_W)) u_buf (
    .clk  (clk),
    .port (mem_bus.store)
  );

  // Pin synchronisers
  logic [PIN_N-1:0] s1_q, s2_q, s3_q;
  logic [PIN_N-1:0] s1_d, s2_d, s3_d;
  logic [PIN_N-1:0] fall, rise;

  always_comb begin
    s1_d = {digital_trigger_in, external_trigger_in_n, start_trigger_in_n};
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign fall = s3_q & ~s2_q;
  assign rise = ~s3_q & s2_q;

  // Configuration and control state
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [DATA_W-1:0]  level_q, level_d;
  logic [CHAN_W-1:0]  tchan_q, tchan_d;
  logic [CNT_W-1:0]   scan_len_q, scan_len_d, total_q, total_d, pre_q, pre_d;
  logic [REG_DW-1:0]  tlimit_q, tlimit_d, us_q, us_d;
  logic [AW-1:0]      rd_addr_q, rd_addr_d;
  logic [REG_DW-1:0]  rdata_q, rdata_d;
  acq_state_t         st_q, st_d;
  logic [CNT_W-1:0]   idx_q, idx_d, scans_q, scans_d;
  logic [AW-1:0]      ring_q, ring_d, post_q, post_d, start_q, start_d;
  logic [AW:0]        words_q, words_d;
  logic [7:0]         pres_q, pres_d;
  logic               done_q, done_d, tout_q, tout_d, stop_q, stop_d;
  logic               full_q, full_d, cfgerr_q, cfgerr_d, pend_q, pend_d;
  logic [DATA_W-1:0]  prev_q, prev_d;
  logic               prev_ok_q, prev_ok_d;

  trig_src_t          src;
  logic               edge_fall, slope_fall, two_trig;
  logic               wr_cmd, arm, sw_go, abort, cfg_ok;
  logic [CNT_W-1:0]   len_eff, post_scans;
  logic [31:0]        need_words, pre_words;
  logic               on_tchan, ana_hit, dig_ev, start_ev, stop_ev, boundary, last_in_scan;
  logic               expired;

  assign src        = trig_src_t'(ctrl_q[CTRL_SRC_LSB +: CTRL_SRC_W]);
  assign edge_fall  = ctrl_q[CTRL_EDGE_BIT];
  assign slope_fall = ctrl_q[CTRL_SLOPE_BIT];
  assign two_trig   = ctrl_q[CTRL_TWO_BIT];
  assign wr_cmd     = reg_wr && reg_addr == REG_CMD;
  assign arm        = wr_cmd && reg_wdata[CMD_ARM_BIT];
  assign sw_go      = wr_cmd && reg_wdata[CMD_SW_BIT];
  assign abort      = wr_cmd && reg_wdata[CMD_ABORT_BIT];
  assign len_eff    = (scan_len_q == '0) ? RST_SCAN_LEN : scan_len_q;
  assign need_words = 32'(total_q) * 32'(len_eff);
  assign pre_words  = 32'(pre_q) * 32'(len_eff);
  assign cfg_ok     = total_q != '0 && pre_q <= total_q && need_words <= 32'(DEPTH);
  // post-trigger count is total minus pretrigger
  assign post_scans = total_q - pre_q;

  // watch the selected channel; any channel may be chosen
  assign on_tchan = sample_valid && sample_chan == tchan_q;
  // level reached while moving in the set direction
  always_comb begin
    if (slope_fall) begin
      ana_hit = on_tchan && prev_ok_q && $signed(prev_q) > $signed(level_q)
                && $signed(sample_data) <= $signed(level_q);
    end else begin
      ana_hit = on_tchan && prev_ok_q && $signed(prev_q) < $signed(level_q)
                && $signed(sample_data) >= $signed(level_q);
    end
  end

  assign dig_ev = edge_fall ? fall[PIN_DIG] : rise[PIN_DIG];

  always_comb begin
    unique case (src)
      SRC_SOFTWARE:  start_ev = sw_go;
      SRC_EXTERNAL:  start_ev = fall[PIN_EXT];
      SRC_START_PIN: start_ev = fall[PIN_START];
      SRC_DIGITAL:   start_ev = dig_ev;
      SRC_ANALOG:    start_ev = ana_hit;
      default:       start_ev = 1'b0;
    endcase
  end

  // stop trigger only in two-trigger mode
  assign stop_ev      = two_trig && dig_ev;
  assign boundary     = sample_valid && idx_q == '0;
  assign last_in_scan = idx_q == len_eff - 16'h0001;
  assign expired      = tlimit_q != '0 && us_q >= tlimit_q;

  always_comb begin
    ctrl_d     = ctrl_q;
    level_d    = level_q;
    tchan_d    = tchan_q;
    scan_len_d = scan_len_q;
    total_d    = total_q;
    pre_d      = pre_q;
    tlimit_d   = tlimit_q;
    rd_addr_d  = rd_addr_q;
    rdata_d    = '0;
    st_d       = st_q;
    idx_d      = idx_q;
    scans_d    = scans_q;
    ring_d     = ring_q;
    post_d     = post_q;
    start_d    = start_q;
    words_d    = words_q;
    pres_d     = pres_q;
    us_d       = us_q;
    done_d     = done_q;
    tout_d     = tout_q;
    stop_d     = stop_q;
    full_d     = full_q;
    cfgerr_d   = cfgerr_q;
    pend_d     = pend_q;
    prev_d     = prev_q;
    prev_ok_d  = prev_ok_q;
    mem_bus.we    = 1'b0;
    mem_bus.waddr = '0;
    mem_bus.wdata = sample_data;
    mem_bus.raddr = rd_addr_q;

    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:      ctrl_d     = reg_wdata[CTRL_W-1:0];
        REG_LEVEL:     level_d    = reg_wdata[DATA_W-1:0];
        REG_TRIG_CHAN: tchan_d    = reg_wdata[CHAN_W-1:0];
        REG_SCAN_LEN:  scan_len_d = reg_wdata[CNT_W-1:0];
        REG_TOTAL:     total_d    = reg_wdata[CNT_W-1:0];
        REG_PRE:       pre_d      = reg_wdata[CNT_W-1:0];
        REG_TLIMIT:    tlimit_d   = reg_wdata;
        REG_RD_ADDR:   rd_addr_d  = reg_wdata[AW-1:0];
        default:       ;
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:      rdata_d = REG_DW'(ctrl_q);
        REG_STATUS:    rdata_d = REG_DW'({pend_q, cfgerr_q, full_q, stop_q, tout_q, done_q,
                                          st_q});
        REG_LEVEL:     rdata_d = REG_DW'(level_q);
        REG_TRIG_CHAN: rdata_d = REG_DW'(tchan_q);
        REG_SCAN_LEN:  rdata_d = REG_DW'(scan_len_q);
        REG_TOTAL:     rdata_d = REG_DW'(total_q);
        REG_PRE:       rdata_d = REG_DW'(pre_q);
        REG_TLIMIT:    rdata_d = tlimit_q;
        REG_START:     rdata_d = REG_DW'(start_q);
        REG_WORDS:     rdata_d = REG_DW'(words_q);
        REG_RD_ADDR:   rdata_d = REG_DW'(rd_addr_q);
        REG_RD_DATA:   rdata_d = REG_DW'(mem_bus.rdata);
        default:       rdata_d = '0;
      endcase
    end

    if (on_tchan) begin
      prev_d    = sample_data;
      prev_ok_d = 1'b1;
    end

    // Microsecond timebase for the limit
    if (st_q == ST_PRE || st_q == ST_WAIT || st_q == ST_POST) begin
      if (pres_q == 8'(US_CYCLES - 1)) begin
        pres_d = '0;
        us_d   = us_q + 32'h0000_0001;
      end else begin
        pres_d = pres_q + 8'h01;
      end
    end

    if ((st_q == ST_PRE || st_q == ST_WAIT) && start_ev) begin
      pend_d = 1'b1;
    end

    if (sample_valid && st_q != ST_IDLE && st_q != ST_DONE) begin
      idx_d = last_in_scan ? '0 : idx_q + 16'h0001;
    end

    unique case (st_q)
      ST_IDLE, ST_DONE: ;
      ST_PRE: begin
        // trigger latched, capture switches at next scan start
        if (boundary && pend_q) begin
          start_d = full_q ? ring_q : '0;
          if (post_scans == '0) begin
            st_d   = ST_DONE;
            done_d = 1'b1;
          end else begin
            st_d          = ST_POST;
            mem_bus.we    = 1'b1;
            mem_bus.waddr = post_q;
            post_d        = post_q + AW'(1);
            words_d       = words_q + (AW + 1)'(1);
          end
        end else if (sample_valid) begin
          // pretrigger ring keeps the newest scans
          mem_bus.we    = 1'b1;
          mem_bus.waddr = ring_q;
          if (32'(ring_q) == pre_words - 32'h1) begin
            ring_d = '0;
            full_d = 1'b1;
          end else begin
            ring_d = ring_q + AW'(1);
          end
          if (!full_q) begin
            words_d = words_q + (AW + 1)'(1);
          end
        end
      end
      ST_WAIT: begin
        // no pretrigger data, full count after trigger
        if (boundary && pend_q) begin
          st_d          = ST_POST;
          mem_bus.we    = 1'b1;
          mem_bus.waddr = post_q;
          post_d        = post_q + AW'(1);
          words_d       = words_q + (AW + 1)'(1);
        end
      end
      ST_POST: begin
        // post-trigger scans written to the buffer
        if (sample_valid) begin
          mem_bus.we    = 1'b1;
          mem_bus.waddr = post_q;
          post_d        = post_q + AW'(1);
          words_d       = words_q + (AW + 1)'(1);
        end
        // second trigger ends the capture early
        if (stop_ev && st_d == ST_POST) begin
          st_d   = ST_DONE;
          done_d = 1'b1;
          stop_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase

    // count post-trigger scans
    // Trigger sample counts too, so one-sample scans end on time
    if (st_d == ST_POST && mem_bus.we && last_in_scan) begin
      scans_d = scans_q + 16'h0001;
      if (scans_d == post_scans) begin
        st_d   = ST_DONE;
        done_d = 1'b1;
      end
    end

    if (expired && (st_q == ST_PRE || st_q == ST_WAIT || st_q == ST_POST)
        && st_d != ST_DONE) begin
      st_d   = ST_DONE;
      done_d = 1'b1;
      tout_d = 1'b1;
    end

    if (abort) begin
      st_d = ST_IDLE;
    end else if (arm) begin
      cfgerr_d  = !cfg_ok;
      st_d      = !cfg_ok ? ST_IDLE : (pre_q != '0 ? ST_PRE : ST_WAIT);
      idx_d     = '0;
      scans_d   = '0;
      ring_d    = '0;
      post_d    = AW'(pre_words);
      start_d   = '0;
      words_d   = '0;
      pres_d    = '0;
      us_d      = '0;
      done_d    = 1'b0;
      tout_d    = 1'b0;
      stop_d    = 1'b0;
      full_d    = 1'b0;
      pend_d    = 1'b0;
      prev_ok_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q     <= '0;
      level_q    <= '0;
      tchan_q    <= '0;
      scan_len_q <= RST_SCAN_LEN;
      total_q    <= RST_TOTAL;
      pre_q      <= '0;
      tlimit_q   <= '0;
      rd_addr_q  <= '0;
      rdata_q    <= '0;
      st_q       <= ST_IDLE;
      idx_q      <= '0;
      scans_q    <= '0;
      ring_q     <= '0;
      post_q     <= '0;
      start_q    <= '0;
      words_q    <= '0;
      pres_q     <= '0;
      us_q       <= '0;
      done_q     <= 1'b0;
      tout_q     <= 1'b0;
      stop_q     <= 1'b0;
      full_q     <= 1'b0;
      cfgerr_q   <= 1'b0;
      pend_q     <= 1'b0;
      prev_q     <= '0;
      prev_ok_q  <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      level_q    <= level_d;
      tchan_q    <= tchan_d;
      scan_len_q <= scan_len_d;
      total_q    <= total_d;
      pre_q      <= pre_d;
      tlimit_q   <= tlimit_d;
      rd_addr_q  <= rd_addr_d;
      rdata_q    <= rdata_d;
      st_q       <= st_d;
      idx_q      <= idx_d;
      scans_q    <= scans_d;
      ring_q     <= ring_d;
      post_q     <= post_d;
      start_q    <= start_d;
      words_q    <= words_d;
      pres_q     <= pres_d;
      us_q       <= us_d;
      done_q     <= done_d;
      tout_q     <= tout_d;
      stop_q     <= stop_d;
      full_q     <= full_d;
      cfgerr_q   <= cfgerr_d;
      pend_q     <= pend_d;
      prev_q     <= prev_d;
      prev_ok_q  <= prev_ok_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign acq_done  = done_q;
  assign acq_busy  = st_q == ST_PRE || st_q == ST_WAIT || st_q == ST_POST;
endmodule

// *** rtl/scan_buffer.sv ***
// Scan memory with one write port and a registered read port
`timescale 1ns/1ns
module scan_buffer #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic clk,
  buf_if.store     port
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    rdata_q <= mem[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule

// *** shared/acq_trig_pkg.sv ***
// Constants, encodings and register map of the acquisition trigger block
package acq_trig_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIME_UNIT_NS  = 1000;
  localparam int US_CYCLES     = TIME_UNIT_NS / CLK_PERIOD_NS;

  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  localparam logic [REG_AW-1:0] REG_CTRL      = 8'h00;
  localparam logic [REG_AW-1:0] REG_CMD       = 8'h04;
  localparam logic [REG_AW-1:0] REG_STATUS    = 8'h08;
  localparam logic [REG_AW-1:0] REG_LEVEL     = 8'h0C;
  localparam logic [REG_AW-1:0] REG_TRIG_CHAN = 8'h10;
  localparam logic [REG_AW-1:0] REG_SCAN_LEN  = 8'h14;
  localparam logic [REG_AW-1:0] REG_TOTAL     = 8'h18;
  localparam logic [REG_AW-1:0] REG_PRE       = 8'h1C;
  localparam logic [REG_AW-1:0] REG_TLIMIT    = 8'h20;
  localparam logic [REG_AW-1:0] REG_START     = 8'h24;
  localparam logic [REG_AW-1:0] REG_WORDS     = 8'h28;
  localparam logic [REG_AW-1:0] REG_RD_ADDR   = 8'h2C;
  localparam logic [REG_AW-1:0] REG_RD_DATA   = 8'h30;

  localparam int CTRL_W         = 6;
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_SRC_W     = 3;
  localparam int CTRL_EDGE_BIT  = 3;
  localparam int CTRL_SLOPE_BIT = 4;
  localparam int CTRL_TWO_BIT   = 5;

  localparam int CMD_ARM_BIT   = 0;
  localparam int CMD_SW_BIT    = 1;
  localparam int CMD_ABORT_BIT = 2;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] RST_SCAN_LEN = 16'h0001;
  localparam logic [CNT_W-1:0] RST_TOTAL    = 16'h0001;

  localparam int PIN_START = 0;
  localparam int PIN_EXT   = 1;
  localparam int PIN_DIG   = 2;
  localparam int PIN_N     = 3;

  typedef enum logic [2:0] {
    SRC_SOFTWARE  = 3'h0,
    SRC_EXTERNAL  = 3'h1,
    SRC_START_PIN = 3'h2,
    SRC_DIGITAL   = 3'h3,
    SRC_ANALOG    = 3'h4
  } trig_src_t;

  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_WAIT, ST_POST, ST_DONE} acq_state_t;
endpackage

// *** shared/buf_if.sv ***
// Write and read port bundle between trigger control and scan buffer
`timescale 1ns/1ns
interface buf_if #(parameter int AW = 10, parameter int DW = 16);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport writer (output we, output waddr, output wdata, output raddr, input rdata);
  modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** verif/acq_trig_properties.sv ***
// Port-level properties of the acquisition trigger control block
`timescale 1ns/1ns
module acq_trig_properties
  import acq_trig_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int CHAN_W = 4
) (
  input wire logic                             clk,
  input wire logic                             sys_rst,
  input wire logic [acq_trig_pkg::REG_AW-1:0]  reg_addr,
  input wire logic [acq_trig_pkg::REG_DW-1:0]  reg_wdata,
  input wire logic                             reg_wr,
  input wire logic                             reg_rd,
  input wire logic [acq_trig_pkg::REG_DW-1:0]  reg_rdata,
  input wire logic                             start_trigger_in_n,
  input wire logic                             external_trigger_in_n,
  input wire logic                             digital_trigger_in,
  input wire logic                             sample_valid,
  input wire logic [CHAN_W-1:0]                sample_chan,
  input wire logic [DATA_W-1:0]                sample_data,
  input wire logic                             acq_busy,
  input wire logic                             acq_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_abort;
    reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_ABORT_BIT];
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == REG_STATUS;
  endsequence

  property p_rdata_quiet;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read");
  property p_busy_from_arm;
    $rose(acq_busy) |-> $past(reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_ARM_BIT]);
  endproperty
  a_busy_from_arm: assert property (p_busy_from_arm)
    else $error("capture started without arm");
  property p_idle_stays;
    !acq_busy && !(reg_wr && reg_addr == REG_CMD) |=> !acq_busy;
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("capture left idle on its own");
  property p_abort_stops;
    s_abort |=> !acq_busy [*2];
  endproperty
  a_abort_stops: assert property (p_abort_stops)
    else $error("abort did not stop capture");
  property p_done_from_busy;
    $rose(acq_done) |-> $past(acq_busy);
  endproperty
  a_done_from_busy: assert property (p_done_from_busy)
    else $error("done without a capture");
  property p_done_stands;
    acq_done && !(reg_wr && reg_addr == REG_CMD) |=> acq_done;
  endproperty
  a_done_stands: assert property (p_done_stands)
    else $error("done dropped without a command");
  property p_busy_done_apart;
    !(acq_busy && acq_done);
  endproperty
  a_busy_done_apart: assert property (p_busy_done_apart)
    else $error("busy and done together");
  property p_status_done;
    s_stat_rd ##0 acq_done |=> reg_rdata[3:0] == 4'hC;
  endproperty
  a_status_done: assert property (p_status_done)
    else $error("status does not show done");
  property p_status_busy;
    s_stat_rd ##0 acq_busy |=> reg_rdata[2:0] inside {[1:3]};
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status state wrong while busy");
endmodule

// *** verif/acquisition_trigger_control_tb_top.sv ***
// Self-checking bench for the acquisition trigger control block
`timescale 1ns/1ns
module acquisition_trigger_control_tb_top;
  import acq_trig_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic        start_trigger_in_n, external_trigger_in_n, digital_trigger_in;
  logic        sample_valid, acq_busy, acq_done;
  logic [3:0]  sample_chan;
  logic [15:0] sample_data;
  int          fails = 0;
  int          n_checks = 0;

  always #4 clk = ~clk;

  trigger_source_model i_src (.clk(clk), .start_trigger_in_n(start_trigger_in_n),
    .external_trigger_in_n(external_trigger_in_n), .digital_trigger_in(digital_trigger_in),
    .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_data(sample_data));

  acquisition_trigger_control #(.DATA_W(16), .DEPTH(1024), .CHAN_W(4)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_trigger_in_n(start_trigger_in_n),
    .external_trigger_in_n(external_trigger_in_n), .digital_trigger_in(digital_trigger_in),
    .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_data(sample_data),
    .acq_busy(acq_busy), .acq_done(acq_done));

  task automatic print_verdict;
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  task automatic rdm(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    rd(a, rv);
    chk(n, rv & m, e);
  endtask

  task automatic rdbuf(input logic [31:0] a, input logic [31:0] e);
    wr(REG_RD_ADDR, a);
    rdm("buffer word", REG_RD_DATA, 32'hFFFFFFFF, e);
  endtask

  task automatic cfg(input logic [31:0] c, input logic [31:0] t, input logic [31:0] p,
                     input logic [31:0] l, input logic [31:0] tl);
    wr(REG_CTRL, c);
    wr(REG_TOTAL, t);
    wr(REG_PRE, p);
    wr(REG_SCAN_LEN, l);
    wr(REG_TLIMIT, tl);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 60 && acq_done !== 1'b1; i++) @(posedge clk);
    chk("done flag", {31'h0, acq_done}, 32'h1);
  endtask

  task automatic t_reset;
    logic [7:0] a [8] = '{REG_CTRL, REG_LEVEL, REG_TRIG_CHAN, REG_SCAN_LEN, REG_TOTAL,
                          REG_PRE, REG_TLIMIT, 8'h3C};
    wr(8'h3C, 32'h5A5A5A5A);
    for (int i = 0; i < 8; i++) begin
      rdm("reset value", a[i], 32'hFFFFFFFF,
          {31'h0, a[i] == REG_SCAN_LEN || a[i] == REG_TOTAL});
    end
  endtask

  task automatic t_soft;
    cfg({29'h0, SRC_SOFTWARE}, 2, 0, 2, 0);
    wr(REG_CMD, 32'h1);
    i_src.sample(4'h0, 16'h0001);
    i_src.sample(4'h0, 16'h0002);
    rdm("held before start", REG_STATUS, 32'h7, 32'h2);
    wr(REG_CMD, 32'h2);
    for (int i = 1; i <= 4; i++) i_src.sample(4'h0, 16'(i * 17));
    wait_done;
    rdm("words stored", REG_WORDS, 32'hFFFFFFFF, 32'h4);
    for (int i = 0; i < 4; i++) rdbuf(i, (i + 1) * 17);
  endtask

  task automatic t_pins;
    logic [2:0] src [4] = '{SRC_EXTERNAL, SRC_START_PIN, SRC_DIGITAL, SRC_DIGITAL};
    int         pin [4] = '{PIN_EXT, PIN_START, PIN_DIG, PIN_DIG};
    logic       fal [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic       aft [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      cfg({28'h0, fal[i], src[i]}, 1, 0, 1, 0);
      i_src.set_pin(pin[i], aft[i]);
      wr(REG_CMD, 32'h1);
      i_src.set_pin(pin[i], ~aft[i]);
      i_src.sample(4'h1, 16'h0005);
      rdm("wrong edge ignored", REG_STATUS, 32'h7, 32'h2);
      i_src.set_pin(pin[i], aft[i]);
      i_src.sample(4'h1, 16'h0055);
      wait_done;
      rdbuf(0, 32'h55);
    end
  endtask

  task automatic t_pre;
    cfg({29'h0, SRC_SOFTWARE}, 3, 2, 1, 0);
    wr(REG_CMD, 32'h1);
    rdm("pretrigger state", REG_STATUS, 32'h7, 32'h1);
    for (int i = 10; i < 15; i++) i_src.sample(4'h0, 16'(i));
    rdm("ring full", REG_STATUS, 32'h47, 32'h41);
    wr(REG_CMD, 32'h2);
    i_src.sample(4'h0, 16'd99);
    wait_done;
    rdm("words stored", REG_WORDS, 32'hFFFFFFFF, 32'h3);
    rdbuf(2, 32'd99);
    rdm("oldest index", REG_START, 32'hFFFFFFFF, 32'h1);
    rdbuf(1, 32'd13);
  endtask

  task automatic t_analog;
    logic [15:0] a;
    logic [15:0] b;
    for (int s = 0; s < 2; s++) begin
      a = s ? 16'd50 : 16'd150;
      b = s ? 16'd150 : 16'd50;
      cfg({27'h0, s[0], 1'b0, SRC_ANALOG}, 1, 0, 1, 0);
      wr(REG_LEVEL, 32'd100);
      wr(REG_TRIG_CHAN, 32'h3);
      wr(REG_CMD, 32'h1);
      i_src.sample(4'h3, a);
      i_src.sample(4'h3, a);
      i_src.sample(4'h3, b);
      i_src.sample(4'h2, b);
      i_src.sample(4'h2, 16'd100);
      rdm("no crossing yet", REG_STATUS, 32'h7, 32'h2);
      i_src.sample(4'h3, 16'd100);
      i_src.sample(4'h3, 16'd7);
      wait_done;
      rdbuf(0, 32'd7);
    end
  endtask

  task automatic t_two;
    // two-trigger mode only with start and stop both wired
    cfg(32'h21, 4, 0, 1, 0);
    i_src.set_pin(PIN_EXT, 1'b1);
    wr(REG_CMD, 32'h1);
    i_src.set_pin(PIN_EXT, 1'b0);
    i_src.sample(4'h0, 16'h0001);
    i_src.sample(4'h0, 16'h0002);
    i_src.set_pin(PIN_DIG, 1'b1);
    i_src.sample(4'h0, 16'h0003);
    wait_done;
    rdm("stopped flag", REG_STATUS, 32'h20, 32'h20);
  endtask

  task automatic t_limit;
    cfg({29'h0, SRC_SOFTWARE}, 1, 0, 1, 2);
    wr(REG_CMD, 32'h1);
    repeat (230) @(posedge clk);
    chk("busy before limit", {31'h0, acq_busy}, 32'h1);
    repeat (40) @(posedge clk);
    chk("done at limit", {31'h0, acq_done}, 32'h1);
    rdm("timeout status", REG_STATUS, 32'h17, 32'h14);
    wr(REG_CMD, 32'h1);
    wr(REG_CMD, 32'h4);
    chk("abort idles", {31'h0, acq_busy}, 32'h0);
    wr(REG_TOTAL, 32'h0);
    wr(REG_CMD, 32'h1);
    rdm("config refused", REG_STATUS, 32'h87, 32'h80);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_soft;
    t_pins;
    t_pre;
    t_analog;
    t_two;
    t_limit;
    print_verdict;
  end

  initial begin
    #(8 * 20000);
    fails++;
    print_verdict;
  end
endmodule

bind acquisition_trigger_control acq_trig_properties #(.DATA_W(DATA_W), .CHAN_W(CHAN_W))
  i_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .start_trigger_in_n(start_trigger_in_n), .external_trigger_in_n(external_trigger_in_n),
  .digital_trigger_in(digital_trigger_in), .sample_valid(sample_valid),
  .sample_chan(sample_chan), .sample_data(sample_data), .acq_busy(acq_busy),
  .acq_done(acq_done));

// *** verif/trigger_source_model.sv ***
// Outside instrument: trigger pins and converter sample stream
`timescale 1ns/1ns
module trigger_source_model
  import acq_trig_pkg::*;
(
  input wire logic  clk,
  output logic      start_trigger_in_n,
  output logic      external_trigger_in_n,
  output logic      digital_trigger_in,
  output logic      sample_valid,
  output logic [3:0]  sample_chan,
  output logic [15:0] sample_data
);
  initial begin
    start_trigger_in_n = 1'b1;
    external_trigger_in_n = 1'b1;
    digital_trigger_in = 1'b0;
    sample_valid = 1'b0;
    sample_chan = 4'h0;
    sample_data = 16'h0000;
  end

  // level held long past the synchroniser
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    case (idx)
      PIN_START: start_trigger_in_n <= v;
      PIN_EXT:   external_trigger_in_n <= v;
      default:   digital_trigger_in <= v;
    endcase
    repeat (6) @(posedge clk);
  endtask

  // Bus shows inverted values between samples
  task automatic sample(input logic [3:0] c, input logic [15:0] d);
    sample_valid <= 1'b1;
    sample_chan <= c;
    sample_data <= d;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_chan <= ~c;
    sample_data <= ~d;
    @(posedge clk);
  endtask
endmodule
